// ### bench/fdi_drive_if_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fdi_drive_if_asserts #(
  parameter int RD_PW_CYC = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // host pins
  input wire logic drive_sel_n,
  input wire logic motor_on_n,
  input wire logic write_gate_n,
  input wire logic side_sel_n,
  input wire logic index_n,
  input wire logic read_data_n,
  input wire logic write_prot_n,
  input wire logic disk_change_n,
  input wire logic ready_n,
  // mechanics and head
  input wire logic disk_present,
  input wire logic index_sense,
  input wire logic wp_hole_open,
  input wire logic read_detect,
  input wire logic head_side1,
  input wire logic write_pulse,
  input wire logic write_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_gone;
    !disk_present[*3] ##0 !drive_sel_n;
  endsequence
  property p_wr_gate;
    write_pulse |-> $past(!write_gate_n && !drive_sel_n && !(wp_hole_open && disk_present));
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write pulse unguarded");
  property p_side;
    $past(aresetn) |-> head_side1 == $past(!side_sel_n);
  endproperty
  a_side: assert property (p_side) else $error("head side wrong");
  property p_wmode;
    write_mode |-> $past(!write_gate_n && !drive_sel_n && !(wp_hole_open && disk_present));
  endproperty
  a_wmode: assert property (p_wmode) else $error("write mode unguarded");
  property p_rdy_off;
    $rose(motor_on_n) |-> ##[1:2] ready_n;
  endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready held after motor off");
  property p_rd_gate;
    $fell(read_data_n) |-> $past(read_detect && !drive_sel_n && !ready_n && write_gate_n);
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read pulse unguarded");
  property p_rd_pw;
    $fell(read_data_n) |-> ##[1:RD_PW_CYC] read_data_n;
  endproperty
  a_rd_pw: assert property (p_rd_pw) else $error("read pulse too long");
  property p_idx;
    $fell(index_n) |-> $past(index_sense && !drive_sel_n && !ready_n);
  endproperty
  a_idx: assert property (p_idx) else $error("index pulse unguarded");
  property p_wprot;
    !drive_sel_n && wp_hole_open && disk_present |=> !write_prot_n;
  endproperty
  a_wprot: assert property (p_wprot) else $error("protect not shown");
  property p_dchg;
    s_gone |=> !disk_change_n;
  endproperty
  a_dchg: assert property (p_dchg) else $error("disk change not shown");
endmodule
bind fdi_drive_if fdi_drive_if_asserts #(.RD_PW_CYC(RD_PW_CYC)) u_chk (.*);
`default_nettype wire

// ### bench/fdi_drive_if_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fdi_drive_if_tb;
  logic        aclk, aresetn, density_lvl, density_pin_i;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [2:0]  s_axi_awprot, s_axi_arprot, c;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        drive_sel_n, motor_on_n, dir_out_n, step_n, write_gate_n, write_data_n;
  logic        side_sel_n, density_pin_o, density_pin_oe, index_n, home_track_flag_n;
  logic        read_data_n, write_prot_n, disk_change_n, ready_n, power_ok, disk_present;
  logic        chuck_done, index_sense, track0_sense, wp_hole_open, hd_hole_open;
  logic        read_detect, head_side1, write_pulse, write_mode, density_2mb, cfg, oe, o;
  int          num_errors, tests_run, m, pulses = 0;
  assign density_pin_i = density_pin_oe ? density_pin_o : density_lvl;
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (write_pulse === 1'b1) pulses <= pulses + 1;
  end
  fdi_host_model HOST (.*);
  fdi_drive_if #(.SIDE_CYC(4), .TRK0_CYC(8), .IDX_PW_CYC(5), .READY_CYC(40), .SEEK_CYC(20),
    .STEP_CYC(24), .ERASE2_CYC(10), .ERASE1_CYC(12), .RD_PW_CYC(2)) DUT (.*);
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr && s_axi_bvalid === 1'b1) break;
      if (!wr && s_axi_rvalid === 1'b1) break;
    end
    {r, d} = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 200) begin
      num_errors++;
      complete_run();
    end
    @(posedge aclk);
  endtask
  task automatic rdp(input logic e);
    read_detect <= 1'b1;
    tick(1);
    read_detect <= 1'b0;
    tick(2);
    chk(read_data_n, e);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    {power_ok, disk_present, chuck_done, density_lvl, aresetn} = 5'h1E;
    {index_sense, track0_sense, wp_hole_open, hd_hole_open, read_detect} = 5'h00;
    num_errors = 0;
    tests_run = 0;
    tick(12);
    aresetn <= 1'b1;
    tick(2);
    bus(1'b0, fdi_pkg::CTRL_OFS, 32'h0);
    chk({r, d}, 34'h0);
    bus(1'b1, fdi_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    chk(r, fdi_pkg::RESP_SLVERR);
    bus(1'b0, 8'h08, 32'h0);
    chk({r, d}, {fdi_pkg::RESP_DECERR, 32'h0});
    bus(1'b0, fdi_pkg::STATUS_OFS, 32'h0);
    chk(d[fdi_pkg::ST_DCHG], 1'b1);
    $display("test registers done");
    {HOST.drive_sel_n, HOST.motor_on_n} <= 2'h0;
    tick(3);
    chk(disk_change_n, 1'b0);
    tick(45);
    index_sense <= 1'b1;
    tick(4);
    index_sense <= 1'b0;
    tick(4);
    chk(ready_n, 1'b0);
    index_sense <= 1'b1;
    tick(2);
    chk(index_n, 1'b0);
    index_sense <= 1'b0;
    tick(8);
    chk(index_n, 1'b1);
    $display("test ready done");
    track0_sense <= 1'b1;
    HOST.step();
    tick(4);
    chk(disk_change_n, 1'b1);
    tick(30);
    chk(home_track_flag_n, 1'b0);
    bus(1'b0, fdi_pkg::STATUS_OFS, 32'h0);
    chk(d[fdi_pkg::ST_SEEK], 1'b1);
    HOST.dir_out_n <= 1'b0;
    HOST.step();
    tick(2);
    chk(home_track_flag_n, 1'b0);
    HOST.dir_out_n <= 1'b1;
    HOST.side_sel_n <= 1'b0;
    tick(2);
    chk(head_side1, 1'b1);
    rdp(1'b1);
    tick(8);
    rdp(1'b0);
    $display("test step and side done");
    HOST.write_gate_n <= 1'b0;
    tick(3);
    chk(write_mode, 1'b1);
    HOST.wpulse();
    chk(pulses, 1);
    wp_hole_open <= 1'b1;
    tick(3);
    chk({write_prot_n, write_mode}, 2'h0);
    HOST.wpulse();
    chk(pulses, 1);
    wp_hole_open <= 1'b0;
    tick(2);
    HOST.write_gate_n <= 1'b1;
    rdp(1'b1);
    tick(6);
    rdp(1'b1);
    rdp(1'b0);
    density_lvl <= 1'b0;
    HOST.write_gate_n <= 1'b0;
    tick(3);
    HOST.write_gate_n <= 1'b1;
    rdp(1'b1);
    tick(8);
    rdp(1'b1);
    rdp(1'b0);
    $display("test write done");
    {hd_hole_open, density_lvl} <= 2'h2;
    for (m = 0; m < 8; m++) begin
      c = m[2:0];
      bus(1'b1, fdi_pkg::CTRL_OFS, {29'h0, c});
      tick(3);
      cfg = c[2] && (c[1] ^ c[0]);
      oe = c[1] && !cfg;
      o = !c[2];
      chk(density_pin_oe, oe);
      if (oe) chk(density_pin_o, o);
      chk(density_2mb, (!cfg && (c[1] ^ c[0])) || ((oe ? o : 1'b0) ^ c[2]));
    end
    s_axi_wstrb <= 4'h0;
    bus(1'b1, fdi_pkg::CTRL_OFS, 32'h0);
    s_axi_wstrb <= 4'hF;
    bus(1'b0, fdi_pkg::CTRL_OFS, 32'h0);
    chk({r, d}, 34'h7);
    $display("test density done");
    {power_ok, chuck_done} <= 2'h1;
    tick(3);
    chk(ready_n, 1'b1);
    {power_ok, chuck_done} <= 2'h2;
    tick(3);
    chk(ready_n, 1'b1);
    {power_ok, chuck_done} <= 2'h3;
    tick(3);
    chk(ready_n, 1'b0);
    HOST.motor_on_n <= 1'b1;
    tick(3);
    chk(ready_n, 1'b1);
    disk_present <= 1'b0;
    tick(4);
    chk(disk_change_n, 1'b0);
    tick(2);
    $display("test motor and disk done");
    complete_run();
  end
endmodule
`default_nettype wire

// ### bench/fdi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdi_host_model (
  // clock
  input  wire logic aclk,
  // host outputs, active low
  output logic      drive_sel_n,
  output logic      motor_on_n,
  output logic      dir_out_n,
  output logic      step_n,
  output logic      write_gate_n,
  output logic      write_data_n,
  output logic      side_sel_n
);
  initial begin
    {drive_sel_n, motor_on_n, dir_out_n, step_n} = 4'hF;
    {write_gate_n, write_data_n, side_sel_n} = 3'h7;
  end
  // low for 0.8 us at least, head moves on the rising edge
  task automatic step();
    step_n <= 1'b0;
    repeat (33) @(posedge aclk);
    step_n <= 1'b1;
    @(posedge aclk);
  endtask
  // 0.1 us pulse, only used while the gate is on
  task automatic wpulse();
    write_data_n <= 1'b0;
    repeat (4) @(posedge aclk);
    write_data_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  // the bench waits out the side settle before gating a write
endmodule
`default_nettype wire

// ### hw/fdi_drive_if.sv
`timescale 1ns/1ps
`default_nettype none
module fdi_drive_if #(
  parameter int unsigned ADDR_W     = 8,
  parameter int unsigned SIDE_CYC   = fdi_pkg::SIDE_CYC,
  parameter int unsigned TRK0_CYC   = fdi_pkg::TRK0_CYC,
  parameter int unsigned IDX_PW_CYC = fdi_pkg::IDX_PW_CYC,
  parameter int unsigned READY_CYC  = fdi_pkg::READY_CYC,
  parameter int unsigned SEEK_CYC   = fdi_pkg::SEEK_CYC,
  parameter int unsigned STEP_CYC   = fdi_pkg::STEP_CYC,
  parameter int unsigned ERASE2_CYC = fdi_pkg::ERASE_2M_CYC,
  parameter int unsigned ERASE1_CYC = fdi_pkg::ERASE_1M_CYC,
  parameter int unsigned RD_PW_CYC  = fdi_pkg::RD_PW_CYC
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // host interface inputs, active low
  input  wire logic              drive_sel_n,
  input  wire logic              motor_on_n,
  input  wire logic              dir_out_n,
  input  wire logic              step_n,
  input  wire logic              write_gate_n,
  input  wire logic              write_data_n,
  input  wire logic              side_sel_n,
  // density pin, two-way
  input  wire logic              density_pin_i,
  output logic                   density_pin_o,
  output logic                   density_pin_oe,
  // host interface outputs, active low
  output logic                   index_n,
  output logic                   home_track_flag_n,
  output logic                   read_data_n,
  output logic                   write_prot_n,
  output logic                   disk_change_n,
  output logic                   ready_n,
  // drive mechanics sense
  input  wire logic              power_ok,
  input  wire logic              disk_present,
  input  wire logic              chuck_done,
  input  wire logic              index_sense,
  input  wire logic              track0_sense,
  input  wire logic              wp_hole_open,
  input  wire logic              hd_hole_open,
  input  wire logic              read_detect,
  // head and channel control
  output logic                   head_side1,
  output logic                   write_pulse,
  output logic                   write_mode,
  output logic                   density_2mb
);

  localparam int TW = fdi_pkg::TMR_W;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W out of range");
  end
  if (SIDE_CYC < 1 || TRK0_CYC < 1 || IDX_PW_CYC < 1 || READY_CYC < 1 ||
      SEEK_CYC < 1 || STEP_CYC < 1 || ERASE2_CYC < 1 || ERASE1_CYC < 1 ||
      RD_PW_CYC < 1) begin : g_chk_min
    $error("timing counts must be at least one cycle");
  end
  if (READY_CYC >= (1 << TW) || STEP_CYC >= (1 << TW) || IDX_PW_CYC >= (1 << TW) ||
      RD_PW_CYC > 255 || SEEK_CYC > STEP_CYC) begin : g_chk_max
    $error("timing counts do not fit the timers");
  end

  function automatic logic [TW-1:0] tmr_dec(input logic [TW-1:0] c);
    return (c == '0) ? '0 : c - TW'(1);
  endfunction

  // word select with every address bit above the map required zero
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return ((a >> 8) == '0) && (a[7:2] == ofs[7:2]);
  endfunction

  // ****************************************************************
  // input edges and decoded levels
  // ****************************************************************
  logic step_n_r, wdata_n_r, wgate_r, side_r, idx_r, disk_r, motor_r;
  logic sel, motor, wgate, side1;
  assign sel   = ~drive_sel_n;
  assign motor = ~motor_on_n;
  assign wgate = ~write_gate_n;
  assign side1 = ~side_sel_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_n_r  <= 1'b1;
      wdata_n_r <= 1'b1;
      wgate_r   <= 1'b0;
      side_r    <= 1'b0;
      idx_r     <= 1'b0;
      disk_r    <= 1'b0;
      motor_r   <= 1'b0;
    end else begin
      step_n_r  <= step_n;
      wdata_n_r <= write_data_n;
      wgate_r   <= wgate;
      side_r    <= side1;
      idx_r     <= index_sense;
      disk_r    <= disk_present;
      motor_r   <= motor;
    end
  end

  logic wp_lvl, step_end, step_ok, side_chg, wg_fall, idx_rise;
  assign wp_lvl   = disk_present & wp_hole_open;
  assign step_end = step_n & ~step_n_r & sel;
  // step ignored while writing or stepping out past track zero
  assign step_ok  = step_end & ~(wgate & ~wp_lvl) & ~(track0_sense & ~dir_out_n);
  assign side_chg = side1 ^ side_r;
  assign wg_fall  = wgate_r & ~wgate;
  assign idx_rise = index_sense & ~idx_r;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0] ctrl_r;
  fdi_pkg::fdi_dens_t mode;
  logic pol_low, cfg_err;
  assign mode    = fdi_pkg::fdi_dens_t'(ctrl_r[fdi_pkg::CTRL_MODE_LSB +: 2]);
  assign pol_low = ctrl_r[fdi_pkg::CTRL_POL_BIT];
  assign cfg_err = pol_low & (mode == fdi_pkg::DENS_AUTO ||
                              mode == fdi_pkg::DENS_AUTO_RPT);

  // ****************************************************************
  // timers
  // ****************************************************************
  logic [TW-1:0] side_t, trk0_t, seek_t, step_t, erase_t, ready_t;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      side_t  <= '0;
      trk0_t  <= '0;
      seek_t  <= '0;
      step_t  <= '0;
    end else begin
      side_t <= side_chg ? TW'(SIDE_CYC) : tmr_dec(side_t);
      trk0_t <= step_ok  ? TW'(TRK0_CYC) : tmr_dec(trk0_t);
      seek_t <= step_ok  ? TW'(SEEK_CYC) : tmr_dec(seek_t);
      step_t <= step_ok  ? TW'(STEP_CYC) : tmr_dec(step_t);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_t <= '0;
    end else if (wgate) begin
      erase_t <= '0;
    end else if (wg_fall) begin
      erase_t <= density_2mb ? TW'(ERASE2_CYC) : TW'(ERASE1_CYC);
    end else begin
      erase_t <= tmr_dec(erase_t);
    end
  end

  // ****************************************************************
  // ready state
  // ****************************************************************
  logic motor_done, idx_seen, ready_st;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_t    <= '0;
      motor_done <= 1'b0;
      idx_seen   <= 1'b0;
    end else if (!motor || !disk_present) begin
      ready_t    <= '0;
      motor_done <= 1'b0;
      idx_seen   <= 1'b0;
    end else begin
      if (!motor_r) begin
        ready_t <= TW'(READY_CYC);
      end else begin
        ready_t <= tmr_dec(ready_t);
      end
      if (motor_r && ready_t == TW'(1)) begin
        motor_done <= 1'b1;
      end
      if (idx_rise) begin
        idx_seen <= 1'b1;
      end
    end
  end
  assign ready_st = power_ok & disk_present & chuck_done & motor & motor_done
                    & idx_seen;

  logic seek_done, rd_ok;
  assign seek_done = (seek_t == '0);
  // the gate release cycle is blocked too, the erase timer only loads there
  assign rd_ok = sel & ~wgate & ~wgate_r & (erase_t == '0) & ready_st & seek_done
                 & (side_t == '0) & (step_t == '0);

  // ****************************************************************
  // write path
  // ****************************************************************
  logic wmode;
  assign wmode = wgate & sel & ~wp_lvl;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_mode  <= 1'b0;
      write_pulse <= 1'b0;
      head_side1  <= 1'b0;
    end else begin
      write_mode  <= wmode;
      write_pulse <= wmode & ~write_data_n & wdata_n_r;
      head_side1  <= side1;
    end
  end

  // ****************************************************************
  // index and read pulses
  // ****************************************************************
  logic [TW-1:0] idx_pw_t;
  logic [7:0]    rd_pw_t;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_pw_t <= '0;
      index_n  <= 1'b1;
    end else begin
      if (idx_rise && sel && ready_st && seek_done) begin
        idx_pw_t <= TW'(IDX_PW_CYC);
        index_n  <= 1'b0;
      end else begin
        idx_pw_t <= tmr_dec(idx_pw_t);
        index_n  <= ~(sel && idx_pw_t > TW'(1));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pw_t     <= '0;
      read_data_n <= 1'b1;
    end else begin
      if (read_detect && rd_ok) begin
        rd_pw_t     <= 8'(RD_PW_CYC);
        read_data_n <= 1'b0;
      end else begin
        rd_pw_t     <= (rd_pw_t == '0) ? '0 : rd_pw_t - 8'h01;
        read_data_n <= ~(rd_ok && rd_pw_t > 8'h01);
      end
    end
  end

  // ****************************************************************
  // level outputs
  // ****************************************************************
  logic dchg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dchg <= 1'b1;
    end else if (!disk_present && disk_r) begin
      dchg <= 1'b1;
    end else if (disk_present && step_end) begin
      dchg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      home_track_flag_n <= 1'b1;
      write_prot_n      <= 1'b1;
      disk_change_n     <= 1'b1;
      ready_n           <= 1'b1;
    end else begin
      home_track_flag_n <= ~(sel & track0_sense & (trk0_t == '0));
      write_prot_n      <= ~(sel & wp_lvl);
      disk_change_n     <= ~(sel & dchg);
      ready_n           <= ~(sel & ready_st);
    end
  end

  // ****************************************************************
  // density handshake
  // ****************************************************************
  logic host_2mb, disk_type_hi;
  assign host_2mb     = density_pin_i ^ pol_low;
  assign disk_type_hi = (hd_hole_open | ~disk_present) ^ pol_low;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      density_2mb    <= 1'b0;
      density_pin_o  <= 1'b0;
      density_pin_oe <= 1'b0;
    end else begin
      density_pin_o <= disk_type_hi;
      if (cfg_err) begin
        density_2mb    <= host_2mb;
        density_pin_oe <= 1'b0;
      end else begin
        unique case (mode)
          fdi_pkg::DENS_HOST: begin
            density_2mb    <= host_2mb;
            density_pin_oe <= 1'b0;
          end
          fdi_pkg::DENS_AUTO: begin
            density_2mb    <= disk_present & hd_hole_open;
            density_pin_oe <= 1'b0;
          end
          fdi_pkg::DENS_AUTO_RPT: begin
            density_2mb    <= disk_present & hd_hole_open;
            density_pin_oe <= 1'b1;
          end
          fdi_pkg::DENS_COMBINED: begin
            density_2mb    <= host_2mb;
            density_pin_oe <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic              aw_got, w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
      end else if (!aw_got && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end else if (!w_got && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_got && w_got) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r       <= fdi_pkg::CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fdi_pkg::RESP_OKAY;
    end else if (aw_got && w_got) begin
      s_axi_bvalid <= 1'b1;
      if (reg_hit(aw_addr, fdi_pkg::CTRL_OFS)) begin
        if (w_strb[0]) begin
          ctrl_r <= w_data[2:0];
        end
        s_axi_bresp <= fdi_pkg::RESP_OKAY;
      end else if (reg_hit(aw_addr, fdi_pkg::STATUS_OFS)) begin
        s_axi_bresp <= fdi_pkg::RESP_SLVERR;
      end else begin
        s_axi_bresp <= fdi_pkg::RESP_DECERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [fdi_pkg::ST_W-1:0] status;
  always_comb begin
    status                       = '0;
    status[fdi_pkg::ST_READY]    = ready_st;
    status[fdi_pkg::ST_SEEK]     = seek_done;
    status[fdi_pkg::ST_RD_OK]    = rd_ok;
    status[fdi_pkg::ST_WMODE]    = wmode;
    status[fdi_pkg::ST_DCHG]     = dchg;
    status[fdi_pkg::ST_DENS_2M]  = density_2mb;
    status[fdi_pkg::ST_SIDE1]    = side1;
    status[fdi_pkg::ST_TRK0]     = track0_sense & (trk0_t == '0);
    status[fdi_pkg::ST_WPROT]    = wp_lvl;
    status[fdi_pkg::ST_CFG_ERR]  = cfg_err;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= fdi_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (reg_hit(s_axi_araddr, fdi_pkg::CTRL_OFS)) begin
        s_axi_rdata <= {29'h0, ctrl_r};
        s_axi_rresp <= fdi_pkg::RESP_OKAY;
      end else if (reg_hit(s_axi_araddr, fdi_pkg::STATUS_OFS)) begin
        s_axi_rdata <= {22'h0, status};
        s_axi_rresp <= fdi_pkg::RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= fdi_pkg::RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### shared/fdi_pkg.sv
`default_nettype none
package fdi_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TMR_W         = 25;

  function automatic int cyc_up(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_dn(input int t_ns);
    int c;
    c = t_ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_SIDE_NS      = 100_000;
  localparam int T_TRK0_NS      = 2_800_000;
  localparam int T_IDX_PW_NS    = 1_500_000;
  localparam int T_READY_NS     = 505_000_000;
  localparam int T_SEEK_NS      = 15_800_000;
  localparam int T_STEP_NS      = 18_000_000;
  localparam int T_ERASE_2M_NS  = 650_000;
  localparam int T_ERASE_1M_NS  = 690_000;
  localparam int T_RD_PW_NS     = 150;

  localparam int SIDE_CYC       = cyc_up(T_SIDE_NS);
  localparam int TRK0_CYC       = cyc_up(T_TRK0_NS);
  localparam int IDX_PW_CYC     = cyc_up(T_IDX_PW_NS);
  localparam int READY_CYC      = cyc_dn(T_READY_NS);
  localparam int SEEK_CYC       = cyc_up(T_SEEK_NS);
  localparam int STEP_CYC       = cyc_up(T_STEP_NS);
  localparam int ERASE_2M_CYC   = cyc_up(T_ERASE_2M_NS);
  localparam int ERASE_1M_CYC   = cyc_up(T_ERASE_1M_NS);
  localparam int RD_PW_CYC      = cyc_up(T_RD_PW_NS);

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POL_BIT  = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  localparam int ST_READY    = 0;
  localparam int ST_SEEK     = 1;
  localparam int ST_RD_OK    = 2;
  localparam int ST_WMODE    = 3;
  localparam int ST_DCHG     = 4;
  localparam int ST_DENS_2M  = 5;
  localparam int ST_SIDE1    = 6;
  localparam int ST_TRK0     = 7;
  localparam int ST_WPROT    = 8;
  localparam int ST_CFG_ERR  = 9;
  localparam int ST_W        = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    DENS_HOST,
    DENS_AUTO,
    DENS_AUTO_RPT,
    DENS_COMBINED
  } fdi_dens_t;

endpackage
`default_nettype wire
